// File: shared/sfct_pkg.sv
// Package for the system control register subset: register numbers,
// secondary opcode and operand field codes, field positions, resets.
// Assumes a core that issues one coprocessor transfer per strobe.
package sfct_pkg;
	localparam logic [3:0] REG_DOMAIN   = 4'h3;
	localparam logic [3:0] REG_RSVD4    = 4'h4;
	localparam logic [3:0] REG_FSTATUS  = 4'h5;
	localparam logic [3:0] REG_FADDR    = 4'h6;
	localparam logic [3:0] REG_CACHEOP  = 4'h7;
	localparam logic [3:0] REG_TLBOP    = 4'h8;
	localparam logic [3:0] REG_TLBLOCK  = 4'ha;
	localparam logic [3:0] OPR_C0  = 4'h0;
	localparam logic [3:0] OPR_C5  = 4'h5;
	localparam logic [3:0] OPR_C6  = 4'h6;
	localparam logic [3:0] OPR_C7  = 4'h7;
	localparam logic [3:0] OPR_C10 = 4'ha;
	localparam logic [3:0] OPR_C13 = 4'hd;
	localparam logic [3:0] OPR_C14 = 4'he;
	localparam logic [2:0] OP2_0 = 3'h0;
	localparam logic [2:0] OP2_1 = 3'h1;
	localparam logic [2:0] OP2_2 = 3'h2;
	localparam logic [2:0] OP2_4 = 3'h4;
	localparam int FS_DOMAIN_LSB = 4;
	localparam int FS_TYPE_LSB   = 0;
	localparam int FS_KEEP_BITS  = 8;
	localparam int DOMAINS       = 16;
	localparam int TLB_PRESERVE_BIT = 0;
	localparam logic [31:0] DOMAIN_RST = 32'h0000_0000;
	localparam logic [31:0] FSTATUS_RST = 32'h0000_0000;
	localparam logic [31:0] FADDR_RST   = 32'h0000_0000;
	// Maintenance commands issued toward cache and TLB logic
	typedef enum logic [3:0] {
		SFCT_OP_NONE,
		SFCT_OP_INV_ALL_IC_DC,
		SFCT_OP_INV_ALL_IC,
		SFCT_OP_INV_ALL_DC,
		SFCT_OP_INV_IC_LINE,
		SFCT_OP_INV_DC_LINE,
		SFCT_OP_CLEAN_DC_VA,
		SFCT_OP_CLEAN_DC_IDX,
		SFCT_OP_CLINV_DC_VA,
		SFCT_OP_CLINV_DC_IDX,
		SFCT_OP_PREFETCH_IC,
		SFCT_OP_INV_TLB_ALL,
		SFCT_OP_INV_ITLB_ALL,
		SFCT_OP_INV_DTLB_ALL,
		SFCT_OP_INV_ITLB_VA,
		SFCT_OP_INV_DTLB_VA
	} sfct_op_e;
endpackage

// File: shared/sfct_fault_if.sv
// Interface carrying one fault capture event between top and status bank.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface sfct_fault_if;
	logic        data_fault;   // Data abort capture strobe
	logic        pref_fault;   // Prefetch abort capture strobe
	logic [3:0]  domain;       // Domain of faulting access
	logic [3:0]  ftype;        // Fault type code
	logic [31:0] addr;         // Remapped virtual address of access
	modport src (output data_fault, pref_fault, domain, ftype, addr);
	modport dst (input  data_fault, pref_fault, domain, ftype, addr);
endinterface

// File: core/sfct_fault_bank.sv
// Fault status pair and fault address register with capture and restore.
// Assumes one write strobe per cycle from the coprocessor decoder.
`timescale 1ns/1ps
module sfct_fault_bank (
	input  wire logic        clock_i,     // Core clock
	input  wire logic        rst_i,       // Async reset, active high
	sfct_fault_if.dst        flt,         // Fault capture events
	input  wire logic        wr_dfs_i,    // Write data fault status
	input  wire logic        wr_pfs_i,    // Write prefetch fault status
	input  wire logic        wr_far_i,    // Write fault address
	input  wire logic [31:0] wdata_i,     // Write data
	output logic      [31:0] dfs_o,       // Data fault status
	output logic      [31:0] pfs_o,       // Prefetch fault status
	output logic      [31:0] far_o        // Fault address
);
	logic [7:0]  dfs_q;
	logic [7:0]  pfs_q;
	logic [31:0] far_q;

	// Capture wins over a restore in the same cycle
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			dfs_q <= sfct_pkg::FSTATUS_RST[7:0];
		end else if (flt.data_fault) begin
			dfs_q <= {flt.domain, flt.ftype};
		end else if (wr_dfs_i) begin
			dfs_q <= wdata_i[7:0];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pfs_q <= sfct_pkg::FSTATUS_RST[7:0];
		end else if (flt.pref_fault) begin
			pfs_q <= {flt.domain, flt.ftype};
		end else if (wr_pfs_i) begin
			pfs_q <= wdata_i[7:0];
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			far_q <= sfct_pkg::FADDR_RST;
		end else if (flt.data_fault) begin
			far_q <= flt.addr;
		end else if (wr_far_i) begin
			far_q <= wdata_i;
		end
	end

	// Status bit 8 and above read as zero; fault address is full width
	assign dfs_o = {24'h00_0000, dfs_q};
	assign pfs_o = {24'h00_0000, pfs_q};
	assign far_o = far_q;

	chk_far_prefetch_hold: assert property (@(posedge clock_i) disable iff
		(rst_i) (flt.pref_fault && !flt.data_fault && !wr_far_i)
		|=> $stable(far_q))
		else $error("Fault address changed on prefetch abort");
	chk_dfs_capture: assert property (@(posedge clock_i) disable iff
		(rst_i) flt.data_fault |=> dfs_o == {24'h00_0000,
		$past(flt.domain), $past(flt.ftype)})
		else $error("Data fault status not captured");
endmodule // sfct_fault_bank

// File: core/sfct_regs.sv
// System control subset: domain access, fault status/address, cache and
// TLB maintenance decode, drain and wait-for-interrupt stalls.
// Assumes the core holds a transfer until stall_o falls.
`timescale 1ns/1ps

module sfct_regs (
	input  wire logic        clock_i,      // Core clock, 50 MHz
	input  wire logic        rst_i,        // Async reset, active high
	input  wire logic        cp_wr_i,      // Coprocessor write strobe
	input  wire logic        cp_rd_i,      // Coprocessor read strobe
	input  wire logic [3:0]  cp_reg_i,     // Primary register number
	input  wire logic [3:0]  cp_opr_i,     // Operand register field
	input  wire logic [2:0]  cp_op2_i,     // Secondary opcode
	input  wire logic [31:0] cp_wdata_i,   // Write data from core
	output logic      [31:0] cp_rdata_o,   // Read data to core
	output logic             stall_o,      // Stall core execution
	output logic             low_power_o,  // Low-power state indicator
	input  wire logic        irq_i,        // Interrupt pending
	input  wire logic        wb_empty_i,   // Write buffer empty
	input  wire logic        dabort_i,     // Data abort event
	input  wire logic        pabort_i,     // Prefetch abort event
	input  wire logic [3:0]  abort_dom_i,  // Faulting domain
	input  wire logic [3:0]  abort_type_i, // Fault type
	input  wire logic [31:0] abort_va_i,   // Faulting virtual address
	output logic             maint_vld_o,  // Maintenance command valid
	output sfct_pkg::sfct_op_e maint_op_o, // Maintenance command
	output logic      [31:0] maint_arg_o,  // Line address or index
	output logic             tlb_preserve_o, // Preserve flag for loads
	output logic      [31:0] domain_o      // Domain permissions to MMU
);
	// ------------------------------------------------------------
	// Domain access register and TLB lockdown preserve flag
	// ------------------------------------------------------------
	logic [31:0] domain_q;
	logic        tlb_pres_q;
	logic        wr_domain;
	logic        wr_tlblock;

	assign wr_domain = cp_wr_i && cp_reg_i == sfct_pkg::REG_DOMAIN;
	assign wr_tlblock = cp_wr_i && cp_reg_i == sfct_pkg::REG_TLBLOCK;

	// Stored verbatim; MMU interprets each two-bit field
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			domain_q <= sfct_pkg::DOMAIN_RST;
		end else if (wr_domain) begin
			domain_q <= cp_wdata_i;
		end
	end
	assign domain_o = domain_q;

	// Only the preserve flag is kept here; lockdown counters live elsewhere
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			tlb_pres_q <= 1'b0;
		end else if (wr_tlblock) begin
			tlb_pres_q <= cp_wdata_i[sfct_pkg::TLB_PRESERVE_BIT];
		end
	end
	assign tlb_preserve_o = tlb_pres_q;

	// ------------------------------------------------------------
	// Fault registers
	// ------------------------------------------------------------
	sfct_fault_if flt ();
	logic [31:0] dfs;
	logic [31:0] pfs;
	logic [31:0] fault_address_reg;
	logic        wr_fs;

	assign flt.data_fault = dabort_i;
	assign flt.pref_fault = pabort_i;
	assign flt.domain     = abort_dom_i;
	assign flt.ftype      = abort_type_i;
	assign flt.addr       = abort_va_i;
	assign wr_fs = cp_wr_i && cp_reg_i == sfct_pkg::REG_FSTATUS;

	sfct_fault_bank u_fault (
		.clock_i  (clock_i),
		.rst_i    (rst_i),
		.flt      (flt),
		.wr_dfs_i (wr_fs && cp_op2_i == sfct_pkg::OP2_0),
		.wr_pfs_i (wr_fs && cp_op2_i == sfct_pkg::OP2_1),
		.wr_far_i (cp_wr_i && cp_reg_i == sfct_pkg::REG_FADDR),
		.wdata_i  (cp_wdata_i),
		.dfs_o    (dfs),
		.pfs_o    (pfs),
		.far_o    (fault_address_reg)
	);

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	// Registered; write-only and reserved numbers read as zero
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			cp_rdata_o <= 32'h0000_0000;
		end else if (cp_rd_i) begin
			unique case (cp_reg_i)
				sfct_pkg::REG_DOMAIN:  cp_rdata_o <= domain_q;
				sfct_pkg::REG_FSTATUS: begin
					cp_rdata_o <= (cp_op2_i == sfct_pkg::OP2_1) ? pfs : dfs;
				end
				sfct_pkg::REG_FADDR:   cp_rdata_o <= fault_address_reg;
				// Register 4, 7 and 8 reads undefined; zero chosen
				default:               cp_rdata_o <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Maintenance decode
	// ------------------------------------------------------------
	sfct_pkg::sfct_op_e op_d;
	logic               arg_used;

	always_comb begin
		op_d = sfct_pkg::SFCT_OP_NONE;
		arg_used = 1'b0;
		if (cp_wr_i && cp_reg_i == sfct_pkg::REG_CACHEOP) begin
			unique case ({cp_opr_i, cp_op2_i})
				{sfct_pkg::OPR_C7, sfct_pkg::OP2_0}:
					op_d = sfct_pkg::SFCT_OP_INV_ALL_IC_DC;
				{sfct_pkg::OPR_C5, sfct_pkg::OP2_0}:
					op_d = sfct_pkg::SFCT_OP_INV_ALL_IC;
				{sfct_pkg::OPR_C6, sfct_pkg::OP2_0}:
					op_d = sfct_pkg::SFCT_OP_INV_ALL_DC;
				{sfct_pkg::OPR_C5, sfct_pkg::OP2_1}: begin
					op_d = sfct_pkg::SFCT_OP_INV_IC_LINE;
					arg_used = 1'b1;
				end
				{sfct_pkg::OPR_C6, sfct_pkg::OP2_1}: begin
					op_d = sfct_pkg::SFCT_OP_INV_DC_LINE;
					arg_used = 1'b1;
				end
				{sfct_pkg::OPR_C10, sfct_pkg::OP2_1}: begin
					op_d = sfct_pkg::SFCT_OP_CLEAN_DC_VA;
					arg_used = 1'b1;
				end
				{sfct_pkg::OPR_C10, sfct_pkg::OP2_2}: begin
					op_d = sfct_pkg::SFCT_OP_CLEAN_DC_IDX;
					arg_used = 1'b1;
				end
				{sfct_pkg::OPR_C14, sfct_pkg::OP2_1}: begin
					op_d = sfct_pkg::SFCT_OP_CLINV_DC_VA;
					arg_used = 1'b1;
				end
				{sfct_pkg::OPR_C14, sfct_pkg::OP2_2}: begin
					op_d = sfct_pkg::SFCT_OP_CLINV_DC_IDX;
					arg_used = 1'b1;
				end
				{sfct_pkg::OPR_C13, sfct_pkg::OP2_1}: begin
					op_d = sfct_pkg::SFCT_OP_PREFETCH_IC;
					arg_used = 1'b1;
				end
				default: op_d = sfct_pkg::SFCT_OP_NONE;
			endcase
		end else if (cp_wr_i && cp_reg_i == sfct_pkg::REG_TLBOP) begin
			unique case ({cp_opr_i, cp_op2_i})
				{sfct_pkg::OPR_C7, sfct_pkg::OP2_0}:
					op_d = sfct_pkg::SFCT_OP_INV_TLB_ALL;
				{sfct_pkg::OPR_C5, sfct_pkg::OP2_0}:
					op_d = sfct_pkg::SFCT_OP_INV_ITLB_ALL;
				{sfct_pkg::OPR_C6, sfct_pkg::OP2_0}:
					op_d = sfct_pkg::SFCT_OP_INV_DTLB_ALL;
				{sfct_pkg::OPR_C5, sfct_pkg::OP2_1}: begin
					op_d = sfct_pkg::SFCT_OP_INV_ITLB_VA;
					arg_used = 1'b1;
				end
				{sfct_pkg::OPR_C6, sfct_pkg::OP2_1}: begin
					op_d = sfct_pkg::SFCT_OP_INV_DTLB_VA;
					arg_used = 1'b1;
				end
				default: op_d = sfct_pkg::SFCT_OP_NONE;
			endcase
		end
	end

	// One-cycle command to cache/TLB logic, which owns the dirty/preserve work
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			maint_op_o  <= sfct_pkg::SFCT_OP_NONE;
			maint_vld_o <= 1'b0;
			maint_arg_o <= 32'h0000_0000;
		end else begin
			maint_op_o  <= op_d;
			maint_vld_o <= op_d != sfct_pkg::SFCT_OP_NONE;
			maint_arg_o <= arg_used ? cp_wdata_i : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// Drain and wait-for-interrupt stall
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SFCT_RUN, SFCT_DRAIN, SFCT_WFI} sfct_st_e;
	sfct_st_e st_q;
	logic     cop_c7;

	assign cop_c7 = cp_wr_i && cp_reg_i == sfct_pkg::REG_CACHEOP
		&& cp_op2_i == sfct_pkg::OP2_4;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= SFCT_RUN;
		end else begin
			unique case (st_q)
				SFCT_RUN: begin
					if (cop_c7 && cp_opr_i == sfct_pkg::OPR_C10) begin
						st_q <= SFCT_DRAIN;
					end else if (cop_c7 && cp_opr_i == sfct_pkg::OPR_C0) begin
						st_q <= SFCT_WFI;
					end
				end
				SFCT_DRAIN: if (wb_empty_i) st_q <= SFCT_RUN;
				SFCT_WFI:   if (irq_i) st_q <= SFCT_RUN;
			endcase
		end
	end

	assign stall_o = st_q != SFCT_RUN;
	assign low_power_o = st_q == SFCT_WFI;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence s_wfi_enter;
		cop_c7 && cp_opr_i == sfct_pkg::OPR_C0 && st_q == SFCT_RUN;
	endsequence
	sequence s_no_irq_hold;
		(!irq_i && low_power_o) [*2];
	endsequence
	sequence s_drain_enter;
		cop_c7 && cp_opr_i == sfct_pkg::OPR_C10 && st_q == SFCT_RUN;
	endsequence

	chk_domain_write: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_domain |=> domain_o == $past(cp_wdata_i))
		else $error("Domain register write lost");
	chk_wfi_halt: assert property (@(posedge clock_i) disable iff (rst_i)
		s_wfi_enter ##1 s_no_irq_hold |=> low_power_o)
		else $error("Wait state left without interrupt");
	chk_wfi_resume: assert property (@(posedge clock_i) disable iff (rst_i)
		(low_power_o && irq_i) |=> !stall_o)
		else $error("Wait state did not resume");
	chk_drain_stall: assert property (@(posedge clock_i) disable iff (rst_i)
		(st_q == SFCT_DRAIN && !wb_empty_i) |=> stall_o)
		else $error("Drain released before buffer empty");
	chk_tlb_all_op: assert property (@(posedge clock_i) disable iff (rst_i)
		(cp_wr_i && cp_reg_i == sfct_pkg::REG_TLBOP
		&& cp_opr_i == sfct_pkg::OPR_C7 && cp_op2_i == sfct_pkg::OP2_0)
		|=> maint_vld_o && maint_op_o == sfct_pkg::SFCT_OP_INV_TLB_ALL
		&& maint_arg_o == 32'h0000_0000)
		else $error("Whole TLB invalidate not issued");
	chk_line_arg: assert property (@(posedge clock_i) disable iff (rst_i)
		(cp_wr_i && cp_reg_i == sfct_pkg::REG_CACHEOP
		&& cp_opr_i == sfct_pkg::OPR_C14 && cp_op2_i == sfct_pkg::OP2_2)
		|=> maint_op_o == sfct_pkg::SFCT_OP_CLINV_DC_IDX
		&& maint_arg_o == $past(cp_wdata_i))
		else $error("Line argument not forwarded");
	chk_pfs_read: assert property (@(posedge clock_i) disable iff (rst_i)
		(cp_rd_i && cp_reg_i == sfct_pkg::REG_FSTATUS
		&& cp_op2_i == sfct_pkg::OP2_1) |=> cp_rdata_o == $past(pfs))
		else $error("Prefetch status read wrong");
	chk_undef_noop: assert property (@(posedge clock_i) disable iff (rst_i)
		(cp_wr_i && cp_reg_i == sfct_pkg::REG_CACHEOP
		&& cp_opr_i == sfct_pkg::OPR_C13 && cp_op2_i == sfct_pkg::OP2_0)
		|=> !maint_vld_o)
		else $error("Unlisted cache op issued");
	chk_wfi_enter: assert property (@(posedge clock_i) disable iff (rst_i)
		s_wfi_enter |=> low_power_o && stall_o)
		else $error("Wait state not entered");
	chk_drain_enter: assert property (@(posedge clock_i) disable iff (rst_i)
		s_drain_enter |=> stall_o && !low_power_o)
		else $error("Drain did not stall");
	chk_far_load: assert property (@(posedge clock_i) disable iff (rst_i)
		dabort_i |=> fault_address_reg == $past(abort_va_i))
		else $error("Fault address not loaded");
	chk_preserve_wr: assert property (@(posedge clock_i) disable iff (rst_i)
		wr_tlblock |=> tlb_preserve_o
		== $past(cp_wdata_i[sfct_pkg::TLB_PRESERVE_BIT]))
		else $error("Preserve flag not stored");
endmodule // sfct_regs

// File: tb/sfct_core_env.sv
// Core-side environment model: write buffer drain and interrupt source.
// Assumes the bench loads the fill level only while no drain is running.
`timescale 1ns/1ps
module sfct_core_env #(
	parameter int IRQ_WAIT = 6     // Cycles asleep before an interrupt
) (
	input  wire logic       clock_i,     // Core clock
	input  wire logic       rst_i,       // Async reset, active high
	input  wire logic       fill_i,      // Load pending write count
	input  wire logic [7:0] fill_cnt_i,  // Pending writes to load
	input  wire logic       low_power_i, // Core asleep
	output logic            wb_empty_o,  // No writes pending
	output logic            irq_o        // Interrupt request level
);
	logic [7:0] pend_q;
	logic [7:0] sleep_q;

	// ----------------------------------------
	// Write buffer
	// ----------------------------------------
	// One entry leaves per cycle, so a drain lasts as long as the fill
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			pend_q <= 8'h00;
		else if (fill_i)
			pend_q <= fill_cnt_i;
		else if (pend_q != 8'h00)
			pend_q <= pend_q - 8'h01;
	end
	assign wb_empty_o = (pend_q == 8'h00);

	// ----------------------------------------
	// Interrupt source
	// ----------------------------------------
	// Raised late on purpose, dropped once the core wakes
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i)
			sleep_q <= 8'h00;
		else if (!low_power_i)
			sleep_q <= 8'h00;
		else if (sleep_q != 8'hff)
			sleep_q <= sleep_q + 8'h01;
	end
	assign irq_o = low_power_i && (sleep_q >= IRQ_WAIT[7:0]);
endmodule // sfct_core_env

// File: tb/sfct_regs_test.sv
// Bench for the system control subset: register access, fault capture,
// maintenance commands and stalls.
// Assumes sfct_core_env stands in for the write buffer and interrupts.
`timescale 1ns/1ps
module sfct_regs_test;
	logic               clock_i = 1'b0;
	logic               rst_i = 1'b1;
	logic               cp_wr_i = 1'b0;
	logic               cp_rd_i = 1'b0;
	logic [3:0]         cp_reg_i = 4'h0;
	logic [3:0]         cp_opr_i = 4'h0;
	logic [2:0]         cp_op2_i = 3'h0;
	logic [31:0]        cp_wdata_i = 32'h0;
	logic               dabort_i = 1'b0;
	logic               pabort_i = 1'b0;
	logic [3:0]         abort_dom_i = 4'h0;
	logic [3:0]         abort_type_i = 4'h0;
	logic [31:0]        abort_va_i = 32'h0;
	logic               fill_i = 1'b0;
	logic [7:0]         fill_cnt_i = 8'h00;
	logic [31:0]        cp_rdata_o;
	logic               stall_o;
	logic               low_power_o;
	logic               irq_i;
	logic               wb_empty_i;
	logic               maint_vld_o;
	sfct_pkg::sfct_op_e maint_op_o;
	logic [31:0]        maint_arg_o;
	logic               tlb_preserve_o;
	logic [31:0]        domain_o;
	logic [31:0]        rv;
	logic [11:0]        ops [15];
	int                 miscompares = 0;
	int                 num_checks = 0;
	int                 i;

	always #10 clock_i = ~clock_i;

	sfct_regs u_sfct_regs (.clock_i(clock_i), .rst_i(rst_i),
		.cp_wr_i(cp_wr_i), .cp_rd_i(cp_rd_i), .cp_reg_i(cp_reg_i),
		.cp_opr_i(cp_opr_i), .cp_op2_i(cp_op2_i), .cp_wdata_i(cp_wdata_i),
		.cp_rdata_o(cp_rdata_o), .stall_o(stall_o),
		.low_power_o(low_power_o), .irq_i(irq_i), .wb_empty_i(wb_empty_i),
		.dabort_i(dabort_i), .pabort_i(pabort_i),
		.abort_dom_i(abort_dom_i), .abort_type_i(abort_type_i),
		.abort_va_i(abort_va_i), .maint_vld_o(maint_vld_o),
		.maint_op_o(maint_op_o), .maint_arg_o(maint_arg_o),
		.tlb_preserve_o(tlb_preserve_o), .domain_o(domain_o));

	sfct_core_env u_sfct_core_env (.clock_i(clock_i), .rst_i(rst_i),
		.fill_i(fill_i), .fill_cnt_i(fill_cnt_i),
		.low_power_i(low_power_o), .wb_empty_o(wb_empty_i),
		.irq_o(irq_i));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One transfer per call; read data lands the cycle after the take
	task automatic xfer(input logic wr, input logic [3:0] r,
		input logic [3:0] o, input logic [2:0] p, input logic [31:0] d);
		chk("reg four unused", 32'h1, {31'h0, r != 4'h4});
		@(negedge clock_i);
		cp_reg_i = r;
		cp_opr_i = o;
		cp_op2_i = p;
		cp_wdata_i = d;
		cp_wr_i = wr;
		cp_rd_i = !wr;
		@(negedge clock_i);
		cp_wr_i = 1'b0;
		cp_rd_i = 1'b0;
		rv = cp_rdata_o;
	endtask

	task automatic abort(input logic d, input logic [3:0] dm,
		input logic [3:0] ty, input logic [31:0] va);
		@(negedge clock_i);
		dabort_i = d;
		pabort_i = !d;
		abort_dom_i = dm;
		abort_type_i = ty;
		abort_va_i = va;
		@(negedge clock_i);
		dabort_i = 1'b0;
		pabort_i = 1'b0;
	endtask

	// No transfer is issued while stalled; the wake cause must precede
	task automatic ride_stall(input logic drain);
		logic cause;
		int   n;
		cause = 1'b0;
		n = 0;
		chk("stall_o", 32'h1, {31'h0, stall_o});
		while (stall_o === 1'b1 && n < 60) begin
			cause = drain ? wb_empty_i : irq_i;
			@(negedge clock_i);
			n++;
		end
		chk("wake cause", 32'h1, {31'h0, cause});
		chk("stall_o", 32'h0, {31'h0, stall_o});
		chk("low_power_o", 32'h0, {31'h0, low_power_o});
	endtask

	task finish_test;
		if (miscompares == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		ops = '{12'h770, 12'h750, 12'h760, 12'h751, 12'h761, 12'h7a1,
			12'h7a2, 12'h7e1, 12'h7e2, 12'h7d1, 12'h870, 12'h850,
			12'h860, 12'h851, 12'h861};
		repeat (5) @(negedge clock_i);
		rst_i = 1'b0;
		chk("domain_o", 32'h0, domain_o);
		xfer(1'b1, 4'h3, 4'h0, 3'h0, 32'he4e4_e4e4);
		xfer(1'b0, 4'h3, 4'h0, 3'h0, 32'h0);
		chk("domain read", 32'he4e4_e4e4, rv);
		for (i = 0; i < sfct_pkg::DOMAINS; i++)
			chk("domain field", {30'h0, i[1:0]}, {30'h0, domain_o[2*i+:2]});
		// Fault capture: data abort then prefetch abort
		abort(1'b1, 4'h3, 4'h5, 32'h8000_1234);
		xfer(1'b0, 4'h5, 4'h0, 3'h0, 32'h0);
		chk("data status", 32'h0000_0035, rv);
		abort(1'b0, 4'h9, 4'hc, 32'h4444_0000);
		xfer(1'b0, 4'h5, 4'h0, 3'h1, 32'h0);
		chk("prefetch status", 32'h0000_009c, rv);
		xfer(1'b0, 4'h5, 4'h0, 3'h0, 32'h0);
		chk("data status", 32'h0000_0035, rv);
		xfer(1'b0, 4'h6, 4'h0, 3'h0, 32'h0);
		chk("fault address", 32'h8000_1234, rv);
		// Debugger restore: read-modify-write of prefetch status, plain writes of data status and address
		xfer(1'b0, 4'h5, 4'h0, 3'h1, 32'h0);
		xfer(1'b1, 4'h5, 4'h0, 3'h1, (rv & 32'hff) ^ 32'hf0);
		xfer(1'b0, 4'h5, 4'h0, 3'h1, 32'h0);
		chk("prefetch restore", 32'h0000_006c, rv);
		xfer(1'b1, 4'h5, 4'h0, 3'h0, 32'h0000_00a2);
		xfer(1'b0, 4'h5, 4'h0, 3'h0, 32'h0);
		chk("data restore", 32'h0000_00a2, rv);
		xfer(1'b1, 4'h6, 4'h0, 3'h0, 32'hdead_beef);
		xfer(1'b0, 4'h6, 4'h0, 3'h0, 32'h0);
		chk("address restore", 32'hdead_beef, rv);
		// Every listed cache and TLB command, nonzero data word
		for (i = 0; i < 15; i++) begin
			xfer(1'b1, ops[i][11:8], ops[i][7:4], ops[i][2:0],
				{28'hc0de_000, i[3:0]});
			chk("maint_vld_o", 32'h1, {31'h0, maint_vld_o});
			chk("maint_op_o", 32'(i + 1), {28'h0, maint_op_o});
			chk("maint_arg_o", (ops[i][2:0] == 3'h0) ? 32'h0 :
				{28'hc0de_000, i[3:0]}, maint_arg_o);
			@(negedge clock_i);
			chk("maint_vld_o", 32'h0, {31'h0, maint_vld_o});
		end
		xfer(1'b1, 4'h7, 4'hd, 3'h0, 32'h0);
		chk("unlisted cache", 32'h0, {31'h0, maint_vld_o});
		xfer(1'b1, 4'h8, 4'ha, 3'h0, 32'h0);
		chk("unlisted tlb", 32'h0, {31'h0, maint_vld_o});
		xfer(1'b1, 4'ha, 4'h0, 3'h0, 32'h1);
		chk("preserve set", 32'h1, {31'h0, tlb_preserve_o});
		xfer(1'b1, 4'ha, 4'h0, 3'h0, 32'h0);
		chk("preserve clear", 32'h0, {31'h0, tlb_preserve_o});
		// Drain after loading six writes (four left at entry), then sleep until interrupt
		@(negedge clock_i);
		fill_i = 1'b1;
		fill_cnt_i = 8'h06;
		@(negedge clock_i);
		fill_i = 1'b0;
		xfer(1'b1, 4'h7, 4'ha, 3'h4, 32'h0);
		ride_stall(1'b1);
		xfer(1'b1, 4'h7, 4'h0, 3'h4, 32'h0);
		chk("low_power_o", 32'h1, {31'h0, low_power_o});
		ride_stall(1'b0);
		finish_test();
	end

	initial begin
		#(20 * 4000);
		miscompares++;
		finish_test();
	end
endmodule // sfct_regs_test
